// File: rtl/bcd_ops_unit.sv
`timescale 1ns/10ps
`include "bcd_ops_consts.svh"
module bcd_ops_unit (
    input wire logic i_core_clk,
    input wire logic i_srst,
    input wire logic i_op_valid,
    input wire bcd_ops_pkg::op_code_e i_op_code,
    input wire logic [7:0] i_mem_rdata,
    input wire logic i_acc_load,
    input wire logic [7:0] i_acc_wdata,
    input wire logic i_flag_load,
    input wire logic i_zero_in,
    input wire logic i_carry_in,
    input wire logic i_half_carry_in,
    output logic o_busy,
    output logic o_done,
    output logic o_mem_we,
    output logic [7:0] o_mem_wdata,
    output logic [7:0] o_acc,
    output logic o_zero_flag,
    output logic o_carry_flag,
    output logic o_half_carry_flag
);

    // ****************************************
    // helpers
    // ****************************************

    // zero test of an eight bit result
    function automatic logic is_zero(input logic [7:0] value);
        is_zero = (value == `BCD_ZERO_BYTE);
    endfunction

    // a bcd digit above nine needs the six step correction
    function automatic logic nibble_over_nine(input logic [3:0] nib);
        nibble_over_nine = (nib > `BCD_NIB_MAX);
    endfunction

    // ****************************************
    // state
    // ****************************************
    bcd_ops_pkg::seq_state_e state_r;
    bcd_ops_pkg::seq_state_e state_nxt;
    // registered copy of the state decode, drives o_busy
    logic busy_r;
    logic busy_nxt;
    bcd_ops_pkg::op_code_e op_r;
    bcd_ops_pkg::op_code_e op_nxt;
    logic [7:0] operand_r;
    logic [7:0] operand_nxt;
    logic [7:0] accumulator_reg_r;
    logic [7:0] accumulator_reg_nxt;
    logic zero_r;
    logic zero_nxt;
    logic carry_r;
    logic carry_nxt;
    logic half_carry_flag_r;
    logic half_carry_flag_nxt;
    logic done_r;
    logic done_nxt;
    logic mem_we_r;
    logic mem_we_nxt;
    logic [7:0] mem_wdata_r;
    logic [7:0] mem_wdata_nxt;

    // datapath intermediates
    logic [7:0] inverted;
    logic lo_fix;
    logic hi_fix;
    logic [8:0] lo_sum;
    logic [8:0] adj_sum;
    logic take;

    // ****************************************
    // sequencer and request capture
    // ****************************************

    // a request counts only while idle and only for a real operation
    assign take = (state_r == bcd_ops_pkg::st_idle) && i_op_valid
        && (i_op_code != bcd_ops_pkg::op_none);

    // a request is taken only while idle; the operand is latched with it
    // requests while busy are dropped, the caller waits for done
    always_comb begin
        state_nxt = state_r;
        op_nxt = op_r;
        operand_nxt = operand_r;
        case (state_r)
            bcd_ops_pkg::st_idle: begin
                if (take) begin
                    state_nxt = bcd_ops_pkg::st_exec;
                    op_nxt = i_op_code;
                    operand_nxt = i_mem_rdata;
                end
            end
            bcd_ops_pkg::st_exec: begin
                state_nxt = bcd_ops_pkg::st_idle; // one execute cycle per operation
            end
            default: begin
                state_nxt = bcd_ops_pkg::st_idle;
            end
        endcase
        busy_nxt = (state_nxt == bcd_ops_pkg::st_exec); // registered so o_busy is a flop
    end

    // sequencer registers; synchronous reset parks it idle
    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            state_r <= bcd_ops_pkg::st_idle;
            busy_r <= 1'b0;
            op_r <= bcd_ops_pkg::op_none;
            operand_r <= `BCD_DATA_RST;
        end else begin
            state_r <= state_nxt;
            busy_r <= busy_nxt;
            op_r <= op_nxt;
            operand_r <= operand_nxt;
        end
    end

    // ****************************************
    // arithmetic
    // ****************************************

    // complement of the latched memory byte
    assign inverted = ~operand_r;

    // low nibble correction on the accumulator
    // nine bits wide so the carry out of the low fix is not lost
    assign lo_fix = nibble_over_nine(accumulator_reg_r[3:0]) || half_carry_flag_r;
    assign lo_sum = {1'b0, accumulator_reg_r} + (lo_fix ? `BCD_LO_ADJ : 9'h000);

    // high nibble correction, judged after the low nibble fix has rippled up
    // a carry out of the low fix means the sum has already passed 99
    assign hi_fix = nibble_over_nine(lo_sum[7:4]) || carry_r || lo_sum[`BCD_CARRY_BIT];
    assign adj_sum = lo_sum + (hi_fix ? `BCD_HI_ADJ : 9'h000);

    // ****************************************
    // execute: accumulator, flags, memory write
    // ****************************************

    // results land at the execute cycle; outside it the load ports may update state
    always_comb begin
        accumulator_reg_nxt = accumulator_reg_r;
        zero_nxt = zero_r;
        carry_nxt = carry_r;
        half_carry_flag_nxt = half_carry_flag_r;
        done_nxt = 1'b0;
        mem_we_nxt = 1'b0;
        mem_wdata_nxt = mem_wdata_r;
        // core loads first, so an operation result below overrides them
        if (i_acc_load) begin
            accumulator_reg_nxt = i_acc_wdata;
        end
        if (i_flag_load) begin
            zero_nxt = i_zero_in;
            carry_nxt = i_carry_in;
            half_carry_flag_nxt = i_half_carry_in;
        end
        // the execute cycle writes the fields its operation owns; decimal adjust also holds zero and half carry, dropping a flag load
        if (state_r == bcd_ops_pkg::st_exec) begin
            done_nxt = 1'b1;
            case (op_r)
                bcd_ops_pkg::invert_in_place_op: begin
                    mem_we_nxt = 1'b1;
                    mem_wdata_nxt = inverted;
                    zero_nxt = is_zero(inverted);
                end
                bcd_ops_pkg::invert_to_accumulator_op: begin
                    accumulator_reg_nxt = inverted;
                    zero_nxt = is_zero(inverted);
                end
                bcd_ops_pkg::decimal_adjust_op: begin
                    mem_we_nxt = 1'b1;
                    mem_wdata_nxt = adj_sum[7:0];
                    // the accumulator keeps its value; the result goes to memory
                    // only carry may move, and only upward
                    carry_nxt = carry_r | adj_sum[`BCD_CARRY_BIT] | hi_fix;
                    zero_nxt = zero_r;
                    half_carry_flag_nxt = half_carry_flag_r;
                end
                // op_none never reaches execute; nothing to write
                default: begin
                    done_nxt = 1'b1;
                end
            endcase
        end
    end

    // result registers; every output below except o_busy is one of these
    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            accumulator_reg_r <= `BCD_ACC_RST;
            zero_r <= `BCD_FLAG_RST;
            carry_r <= `BCD_FLAG_RST;
            half_carry_flag_r <= `BCD_FLAG_RST;
            done_r <= 1'b0;
            mem_we_r <= 1'b0;
            mem_wdata_r <= `BCD_DATA_RST;
        end else begin
            accumulator_reg_r <= accumulator_reg_nxt;
            zero_r <= zero_nxt;
            carry_r <= carry_nxt;
            half_carry_flag_r <= half_carry_flag_nxt;
            done_r <= done_nxt;
            mem_we_r <= mem_we_nxt;
            mem_wdata_r <= mem_wdata_nxt;
        end
    end

    // ****************************************
    // outputs, all straight from flip-flops
    // ****************************************
    assign o_busy = busy_r;
    assign o_done = done_r;
    assign o_mem_we = mem_we_r;
    assign o_mem_wdata = mem_wdata_r;
    assign o_acc = accumulator_reg_r;
    assign o_zero_flag = zero_r;
    assign o_carry_flag = carry_r;
    assign o_half_carry_flag = half_carry_flag_r;

endmodule // bcd_ops_unit

// File: rtl/bcd_ops_consts.svh
`ifndef BCD_OPS_CONSTS_SVH
`define BCD_OPS_CONSTS_SVH
// Behaviour
// - invert in place: memory byte inverted and written back, zero flag updated
// - invert to accumulator: inverted byte into accumulator, memory untouched, zero updated
// - decimal adjust: accumulator value corrected to valid bcd and stored to memory byte, accumulator unchanged
// - low nibble above 9 or half carry set: add 6 to low nibble
// - high nibble above 9 or carry set: add 6 to high nibble
// - decimal adjust touches only carry; carry set when decimal sum exceeds 99

// ****************************************
// data widths and constants
// ****************************************
`define BCD_DATA_W 8
`define BCD_NIB_W 4
`define BCD_NIB_MAX 4'h9
`define BCD_NIB_ADJ 4'h6
`define BCD_LO_ADJ 9'h006
`define BCD_HI_ADJ 9'h060
`define BCD_CARRY_BIT 8

// ****************************************
// reset values
// ****************************************
`define BCD_ACC_RST 8'h00
`define BCD_FLAG_RST 1'b0
`define BCD_DATA_RST 8'h00
`define BCD_ZERO_BYTE 8'h00

`endif

// File: rtl/bcd_ops_pkg.sv
package bcd_ops_pkg;
    // ****************************************
    // operation select and sequencer states
    // ****************************************
    typedef enum logic [1:0] {
        op_none,
        invert_in_place_op,
        invert_to_accumulator_op,
        decimal_adjust_op
    } op_code_e;

    typedef enum logic [0:0] {
        st_idle,
        st_exec
    } seq_state_e;
endpackage

// File: verif/bcd_ops_unit_assertions.sv
`timescale 1ns/10ps
module bcd_ops_checker (
    input wire logic i_core_clk,
    input wire logic i_srst,
    input wire logic i_op_valid,
    input wire bcd_ops_pkg::op_code_e i_op_code,
    input wire logic [7:0] i_mem_rdata,
    input wire logic i_flag_load,
    input wire logic o_busy,
    input wire logic o_done,
    input wire logic o_mem_we,
    input wire logic [7:0] o_mem_wdata,
    input wire logic [7:0] o_acc,
    input wire logic o_zero_flag,
    input wire logic o_carry_flag
);
    // ****************
    // accepted requests by kind
    // ****************
    wire logic take = i_op_valid && i_op_code != bcd_ops_pkg::op_none && !o_busy;
    wire logic inp = take && i_op_code == bcd_ops_pkg::invert_in_place_op;
    wire logic ina = take && i_op_code == bcd_ops_pkg::invert_to_accumulator_op;
    wire logic adj = take && i_op_code == bcd_ops_pkg::decimal_adjust_op;
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (i_srst);
    busy_start_a: assert property (take |=> o_busy) else $error("no busy");
    done_follow_a: assert property (o_busy |=> o_done && !o_busy)
        else $error("no done");
    inv_write_a: assert property (
        inp |-> ##2 o_mem_we && o_mem_wdata == ~$past(i_mem_rdata, 2))
        else $error("bad write");
    inv_acc_a: assert property (
        ina |-> ##2 !o_mem_we && o_acc == ~$past(i_mem_rdata, 2))
        else $error("bad acc");
    inv_zero_a: assert property (
        (inp || ina) |-> ##2 o_zero_flag == ($past(i_mem_rdata, 2) == 8'hFF))
        else $error("bad zero");
    adj_write_a: assert property (adj |-> ##2 o_mem_we && o_done)
        else $error("no store");
    adj_zero_a: assert property (
        (adj && !i_flag_load) ##1 !i_flag_load |=> $stable(o_zero_flag))
        else $error("zero moved");
    adj_carry_a: assert property (
        (adj && o_carry_flag && !i_flag_load) ##1 !i_flag_load |=> o_carry_flag)
        else $error("carry lost");
    cover property (inp);
    cover property (ina);
    cover property (adj ##2 o_carry_flag);
endmodule // bcd_ops_checker
bind bcd_ops_unit bcd_ops_checker bcd_ops_checker_inst (.*);

// File: verif/mem_model.sv
`timescale 1ns/10ps
// ****************
// one addressed data memory byte
// ****************
module mem_model (
    input wire logic i_core_clk,
    input wire logic i_we,
    input wire logic [7:0] i_wd,
    input wire logic i_set,
    input wire logic [7:0] i_sd,
    output logic [7:0] o_rd
);
    // bench presets the byte, the unit writes results back
    always @(posedge i_core_clk) begin
        if (i_set) o_rd <= i_sd;
        else if (i_we) o_rd <= i_wd;
    end
endmodule // mem_model

// File: verif/tb.sv
`timescale 1ns/10ps
module tb;
    logic i_core_clk = 0, i_srst = 1, i_op_valid = 0, i_acc_load = 0, i_flag_load = 0, set = 0;
    logic i_zero_in = 0, i_carry_in = 0, i_half_carry_in = 0;
    logic o_busy, o_done, o_mem_we, o_zero_flag, o_carry_flag, o_half_carry_flag;
    logic [7:0] i_acc_wdata = 8'h00, sd = 8'h00, i_mem_rdata, o_mem_wdata, o_acc, d;
    logic [8:0] e;
    logic [9:0] v;
    logic [31:0] r;
    logic [9:0] dv [4] = '{10'h09A, 10'h300, 10'h099, 10'h1A5};
    bcd_ops_pkg::op_code_e i_op_code = bcd_ops_pkg::op_none;
    int errors = 0, samples_checked = 0, seed = 94803, n, k;
    // ****************
    // clock, unit and memory
    // ****************
    initial forever #50 i_core_clk = ~i_core_clk;
    bcd_ops_unit bcd_ops_unit_inst (.*);
    mem_model mem_model_inst (.i_core_clk, .i_we(o_mem_we), .i_wd(o_mem_wdata), .i_set(set),
        .i_sd(sd), .o_rd(i_mem_rdata));
    // compare, step, verdict
    task automatic cmp(input logic [8:0] got, input logic [8:0] exp);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic tick;
        @(posedge i_core_clk);
        #1;
    endtask
    task automatic results;
        $display("errors %0d samples_checked %0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // preset memory, request, wait for done
    task automatic run(input bcd_ops_pkg::op_code_e c, input logic [7:0] x);
        set = 1;
        sd = x;
        tick();
        set = 0;
        i_op_valid = 1;
        i_op_code = c;
        tick();
        i_op_valid = 0;
        cmp({8'h00, o_busy}, 9'h001);
        for (n = 0; n < 4 && o_done !== 1'b1; n++) tick();
        if (n == 4) begin
            errors++;
            results();
        end
        cmp(9'(n), 9'h001);
    endtask
    // decimal adjust expectation: {carry, byte}
    function automatic logic [8:0] adj(input logic [7:0] a, input logic c, input logic h);
        logic [8:0] s;
        s = {1'b0, a};
        if (a[3:0] > 4'h9 || h) s = s + 9'h006;
        if (s[7:4] > 4'h9 || c || s[8]) s = s + 9'h060;
        return {s[8] | c, s[7:0]};
    endfunction
    // ****************
    // scenarios
    // ****************
    initial begin
        repeat (2) tick();
        cmp({o_carry_flag, o_acc}, 9'h000);
        i_srst = 0;
        // a strobe with op_none must start nothing
        i_op_valid = 1;
        tick();
        cmp({8'h00, o_busy}, 9'h000);
        i_op_valid = 0;
        tick();
        cmp({8'h00, o_done}, 9'h000);
        for (k = 0; k < 60; k++) begin
            r = $random(seed);
            d = (k == 0) ? 8'hFF : (k == 1) ? 8'h00 : r[7:0];
            run(bcd_ops_pkg::invert_in_place_op, d);
            cmp({o_mem_we, o_mem_wdata}, {1'b1, ~d});
            cmp({8'h00, o_zero_flag}, {8'h00, d == 8'hFF});
            tick();
            cmp({1'b0, i_mem_rdata}, {1'b0, ~d});
            run(bcd_ops_pkg::invert_to_accumulator_op, d);
            cmp({o_mem_we, o_acc}, {1'b0, ~d});
            cmp({8'h00, o_zero_flag}, {8'h00, d == 8'hFF});
            tick();
            cmp({1'b0, i_mem_rdata}, {1'b0, d});
            v = (k < 4) ? dv[k] : r[25:16];
            i_acc_load = 1;
            i_flag_load = 1;
            i_acc_wdata = v[7:0];
            {i_carry_in, i_half_carry_in, i_zero_in} = {v[9:8], r[31]};
            tick();
            i_acc_load = 0;
            i_flag_load = 0;
            e = adj(v[7:0], v[9], v[8]);
            run(bcd_ops_pkg::decimal_adjust_op, r[15:8]);
            cmp({o_mem_we, o_mem_wdata}, {1'b1, e[7:0]});
            cmp({o_carry_flag, o_acc}, {e[8], v[7:0]});
            cmp({7'h00, o_zero_flag, o_half_carry_flag}, {7'h00, r[31], v[8]});
        end
        results();
    end
endmodule // tb
